// ---- src/fc_map.svh ----
// fc_map.svh: register map, field positions, reset values and timing counts of the
// flash operation controller. Assumes a 100 MHz clock and a 32-bit APB register port.
// Notes on behaviour
// - Program suspend request sets op-done after about 9.4 us plus four clocks.
// - Erase suspend request sets op-done after about 16 us plus four clocks.
// - Clearing both suspend bits with high voltage enabled resumes and drops op-done.
// - High-voltage enable rising from idle with the array ready starts the operation and clears op-done at once.
// - High-voltage enable falling aborts; op-done set within 20.8 us plus four clocks.
// - Leaving low power holds the array not ready for 45 us plus seven clocks.
// - Integrity-check enable rising from idle with the array ready starts a check and clears check-done at once.
// - Clearing both check suspend and breakpoint control resumes and clears check-done.
// - Check enable falling aborts integrity check; done within 80 ns plus fifteen clocks.
// - Check suspend during integrity check sets check-done within the same bound.
// - Margin read abort sets check-done between 10.36 and 20.42 us plus four clocks.
// - Margin read suspend sets check-done within that same window.
// - Sequential misses save as many clocks as the pipeline setting, one fewer at wait 0 with pipeline 3.
// - Integrity check reads 512, 1024, 2048 or 8192 locations by block size.
`ifndef FC_MAP_SVH
`define FC_MAP_SVH

`define FC_OFS_CFG 8'h00
`define FC_OFS_STAT 8'h04
`define FC_OFS_TEST 8'h08
`define FC_OFS_PCFG 8'h0c
`define FC_OFS_IRQ 8'h10
`define FC_OFS_MASK 8'h14

`define FC_CFG_W 5
`define FC_CFG_HVE 0
`define FC_CFG_PSP 1
`define FC_CFG_ESP 2
`define FC_CFG_ERASE 3
`define FC_CFG_LPM 4
`define FC_CFG_RST 5'h00

`define FC_STAT_W 6
`define FC_STAT_OPDONE 0
`define FC_STAT_CKDONE 1
`define FC_STAT_READY 2
`define FC_STAT_OPBUSY 3
`define FC_STAT_CKBUSY 4
`define FC_STAT_HALTED 5

`define FC_TEST_W 6
`define FC_TEST_EN 0
`define FC_TEST_SUSP 1
`define FC_TEST_BP 2
`define FC_TEST_MARGIN 3
`define FC_TEST_BLK 4
`define FC_TEST_RST 6'h00

`define FC_PCFG_W 6
`define FC_PCFG_WAIT 0
`define FC_PCFG_PIPE 4
`define FC_PCFG_RST 6'h12

`define FC_IRQ_W 3
`define FC_IRQ_OPDONE 0
`define FC_IRQ_CKDONE 1
`define FC_IRQ_READY 2

`define FC_LAST_16K 13'h01ff
`define FC_LAST_32K 13'h03ff
`define FC_LAST_64K 13'h07ff
`define FC_LAST_256K 13'h1fff

`define FC_RD_BASE 4'h3
`define FC_RD_HIT 4'h1

`define FC_CLK_NS 10
`define FC_T_PROG_SUSP_NS 9400
`define FC_T_ERASE_SUSP_NS 16000
`define FC_T_OP_ABORT_NS 20800
`define FC_T_MARGIN_STOP_NS 10360
`define FC_T_CHECK_STOP_NS 80
`define FC_T_WAKE_NS 45000
`define FC_PROG_SUSP_CYC (`FC_T_PROG_SUSP_NS / `FC_CLK_NS + 4)
`define FC_ERASE_SUSP_CYC (`FC_T_ERASE_SUSP_NS / `FC_CLK_NS + 4)
`define FC_OP_ABORT_CYC (`FC_T_OP_ABORT_NS / `FC_CLK_NS + 4)
`define FC_MARGIN_STOP_CYC ((`FC_T_MARGIN_STOP_NS + `FC_CLK_NS - 1) / `FC_CLK_NS + 4)
`define FC_CHECK_STOP_CYC (`FC_T_CHECK_STOP_NS / `FC_CLK_NS + 15)
`define FC_WAKE_CYC (`FC_T_WAKE_NS / `FC_CLK_NS + 7)
`define FC_OP_CYC 1000

`endif

// ---- src/fc_pkg.sv ----
// fc_pkg.sv: state types of the flash operation controller.
// Assumes the constants of fc_map.svh are included where needed.
package fc_pkg;
   typedef enum logic [2:0] {OP_IDLE, OP_RUN, OP_SUSPENDING, OP_SUSPENDED, OP_ABORTING} fc_op_t;
   typedef enum logic [1:0] {CK_IDLE, CK_READ, CK_STOP, CK_HALT} fc_ck_t;
endpackage

// ---- src/fc_rd_if.sv ----
// fc_rd_if.sv: one flash read request and its completion strobe.
// Assumes one request is in flight at a time.
`timescale 1ns/1ps
interface fc_rd_if;
   logic valid;
   logic ready;
   logic hit;
   logic seq;
   logic done;
   modport ctrl (output valid, output hit, output seq, input ready, input done);
   modport tmr (input valid, input hit, input seq, output ready, output done);
endinterface

// ---- src/fc_timer.sv ----
// fc_timer.sv: loadable down counter that reports when it has run out.
// Assumes the owner loads it before it looks at the zero flag.
`timescale 1ns/1ps
module fc_timer #(
   parameter int W = 16
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_load,
   input wire logic [W-1:0] i_value,
   input wire logic i_run,
   output logic o_zero
);
   logic [W-1:0] count_reg;

   // Load wins over counting; the count rests at zero until reloaded.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         count_reg <= '0;
      end else if (i_load) begin
         count_reg <= i_value;
      end else if (i_run && count_reg != '0) begin
         count_reg <= count_reg - 1'b1;
      end
   end

   assign o_zero = (count_reg == '0);
endmodule

// ---- src/fc_rd_timer.sv ----
// fc_rd_timer.sv: paces flash reads by wait states, pipelining and mini-cache hits.
// Assumes the requester holds valid until ready and accepts done as a pulse.
`timescale 1ns/1ps
`include "fc_map.svh"
module fc_rd_timer (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [2:0] i_wait,
   input wire logic [1:0] i_pipe,
   fc_rd_if.tmr rd
);
   logic busy_reg;
   logic [3:0] cnt_reg;
   logic [3:0] lat_miss;
   logic [3:0] lat_cut;
   logic [3:0] lat;
   logic accept;

   assign lat_miss = `FC_RD_BASE + {1'b0, i_wait};
   assign lat_cut = rd.seq ? lat_miss - {2'b00, i_pipe} : lat_miss;
   // hit latency; a read never takes under one clock.
   assign lat = rd.hit ? `FC_RD_HIT : ((lat_cut == 4'h0) ? `FC_RD_HIT : lat_cut);
   assign rd.done = busy_reg && (cnt_reg == 4'h0);
   assign rd.ready = !busy_reg || rd.done;
   assign accept = rd.valid && rd.ready;

   // A new read may start in the cycle the previous one completes.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         busy_reg <= 1'b0;
         cnt_reg <= 4'h0;
      end else if (accept) begin
         busy_reg <= 1'b1;
         cnt_reg <= lat - 4'h1;
      end else if (rd.done) begin
         busy_reg <= 1'b0;
      end else if (busy_reg) begin
         cnt_reg <= cnt_reg - 4'h1;
      end
   end
endmodule

// ---- src/fc_flash_ctrl.sv ----
// fc_flash_ctrl.sv: flash program/erase and integrity check sequencer with APB registers.
// Assumes a single 100 MHz clock, an APB master and one outstanding read on the read port.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "fc_map.svh"
module fc_flash_ctrl
   import fc_pkg::*;
#(
   parameter int unsigned P_OP_CYCLES = `FC_OP_CYC,
   parameter int unsigned P_WAKE_CYCLES = `FC_WAKE_CYC
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_rd_valid,
   input wire logic i_rd_hit,
   input wire logic i_rd_seq,
   output logic o_rd_ready,
   output logic o_rd_done,
   output logic o_op_done,
   output logic o_chk_done,
   output logic o_array_ready,
   output logic o_irq
);
   logic rst_meta_reg;
   logic rst_sync_reg;
   logic rst_n;
   logic [`FC_CFG_W-1:0] module_config_reg;
   logic [`FC_CFG_W-1:0] cfg_next;
   logic [`FC_TEST_W-1:0] user_test_reg;
   logic [`FC_TEST_W-1:0] test_next;
   logic [`FC_PCFG_W-1:0] platform_flash_config_reg;
   logic [`FC_PCFG_W-1:0] pcfg_next;
   logic [`FC_IRQ_W-1:0] irq_stat_reg;
   logic [`FC_IRQ_W-1:0] irq_stat_next;
   logic [`FC_IRQ_W-1:0] irq_mask_reg;
   logic [`FC_IRQ_W-1:0] irq_mask_next;
   logic [`FC_IRQ_W-1:0] irq_event;
   logic [`FC_IRQ_W-1:0] irq_w1c;
   logic [`FC_STAT_W-1:0] stat_word;
   logic [31:0] prdata_reg;
   logic [31:0] rd_mux;
   fc_op_t op_state_reg;
   fc_op_t op_next;
   fc_ck_t ck_state_reg;
   fc_ck_t ck_next;
   logic op_done_reg;
   logic op_done_next;
   logic ck_done_reg;
   logic ck_done_next;
   logic ready_reg;
   logic ready_next;
   logic wake_act_reg;
   logic wake_act_next;
   logic op_dly_load;
   logic [15:0] op_dly_val;
   logic op_dly_zero;
   logic op_prog_load;
   logic op_prog_zero;
   logic ck_dly_load;
   logic ck_dly_zero;
   logic wake_zero;
   logic [12:0] ck_addr_reg;
   logic [12:0] ck_last;
   logic ck_first_reg;
   logic ck_abort_reg;
   logic ck_abort_next;
   logic owner_ck_reg;
   logic ck_owns;
   logic ck_valid;
   logic ck_rd_done;
   logic rd_accept;
   fc_rd_if rd_bus ();

   // Release the asynchronous reset through two flops so all state leaves reset together.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rst_n = rst_sync_reg;

   // APB decode; the slave never inserts wait states.
   wire acc = i_psel && i_penable;
   wire wr_en = acc && i_pwrite;
   wire sel_cfg = (i_paddr == `FC_OFS_CFG);
   wire sel_stat = (i_paddr == `FC_OFS_STAT);
   wire sel_test = (i_paddr == `FC_OFS_TEST);
   wire sel_pcfg = (i_paddr == `FC_OFS_PCFG);
   wire sel_irq = (i_paddr == `FC_OFS_IRQ);
   wire sel_mask = (i_paddr == `FC_OFS_MASK);
   wire hit_any = sel_cfg || sel_stat || sel_test || sel_pcfg || sel_irq || sel_mask;
   assign o_pready = 1'b1;
   assign o_pslverr = acc && !hit_any;
   assign o_prdata = prdata_reg;

   // Next register values; the sequencers act on these so a write takes effect on its own edge.
   assign cfg_next = (wr_en && sel_cfg) ? i_pwdata[`FC_CFG_W-1:0] : module_config_reg;
   assign test_next = (wr_en && sel_test) ? i_pwdata[`FC_TEST_W-1:0] : user_test_reg;
   assign pcfg_next = (wr_en && sel_pcfg) ? i_pwdata[`FC_PCFG_W-1:0] : platform_flash_config_reg;
   assign irq_mask_next = (wr_en && sel_mask) ? i_pwdata[`FC_IRQ_W-1:0] : irq_mask_reg;
   assign irq_w1c = (wr_en && sel_irq) ? i_pwdata[`FC_IRQ_W-1:0] : '0;

   // Control bit views: current value and value after this edge's write.
   wire hve_q = module_config_reg[`FC_CFG_HVE];
   wire hve_n = cfg_next[`FC_CFG_HVE];
   wire psp_n = cfg_next[`FC_CFG_PSP];
   wire esp_n = cfg_next[`FC_CFG_ESP];
   wire erase_n = cfg_next[`FC_CFG_ERASE];
   wire lpm_q = module_config_reg[`FC_CFG_LPM];
   wire lpm_n = cfg_next[`FC_CFG_LPM];
   wire hve_rise = hve_n && !hve_q;
   wire ck_en_q = user_test_reg[`FC_TEST_EN];
   wire ck_en_n = test_next[`FC_TEST_EN];
   wire ck_sus_n = test_next[`FC_TEST_SUSP];
   wire ck_bp_n = test_next[`FC_TEST_BP];
   wire margin_n = test_next[`FC_TEST_MARGIN];
   wire [1:0] blk_q = user_test_reg[`FC_TEST_BLK +: 2];
   wire ck_en_rise = ck_en_n && !ck_en_q;
   wire lpm_fall = lpm_q && !lpm_n;
   wire [2:0] wait_q = platform_flash_config_reg[`FC_PCFG_WAIT +: 3];
   wire [1:0] pipe_q = platform_flash_config_reg[`FC_PCFG_PIPE +: 2];

   // Status word shows the sequencers' own state.
   assign stat_word[`FC_STAT_OPDONE] = op_done_reg;
   assign stat_word[`FC_STAT_CKDONE] = ck_done_reg;
   assign stat_word[`FC_STAT_READY] = ready_reg;
   assign stat_word[`FC_STAT_OPBUSY] = (op_state_reg != OP_IDLE);
   assign stat_word[`FC_STAT_CKBUSY] = (ck_state_reg != CK_IDLE);
   assign stat_word[`FC_STAT_HALTED] = (op_state_reg == OP_SUSPENDED) || (ck_state_reg == CK_HALT);

   // Read data is captured in the setup cycle, so the access phase can finish at once.
   assign rd_mux = sel_cfg ? {{(32-`FC_CFG_W){1'b0}}, module_config_reg} :
                   sel_stat ? {{(32-`FC_STAT_W){1'b0}}, stat_word} :
                   sel_test ? {{(32-`FC_TEST_W){1'b0}}, user_test_reg} :
                   sel_pcfg ? {{(32-`FC_PCFG_W){1'b0}}, platform_flash_config_reg} :
                   sel_irq ? {{(32-`FC_IRQ_W){1'b0}}, irq_stat_reg} :
                   sel_mask ? {{(32-`FC_IRQ_W){1'b0}}, irq_mask_reg} : 32'h0;

   // Program/erase sequencer.
   always_comb begin
      op_next = op_state_reg;
      op_dly_load = 1'b0;
      op_dly_val = 16'h0;
      op_prog_load = 1'b0;
      case (op_state_reg)
         OP_IDLE: begin
            if (hve_rise && ready_reg) begin
               op_next = OP_RUN;
               op_prog_load = 1'b1;
            end
         end
         OP_RUN: begin
            if (!hve_n) begin
               op_next = OP_ABORTING;
               op_dly_load = 1'b1;
               op_dly_val = 16'(`FC_OP_ABORT_CYC - 1);
            end else if (psp_n && !erase_n) begin
               op_next = OP_SUSPENDING;
               op_dly_load = 1'b1;
               op_dly_val = 16'(`FC_PROG_SUSP_CYC - 1);
            end else if (esp_n && erase_n) begin
               op_next = OP_SUSPENDING;
               op_dly_load = 1'b1;
               op_dly_val = 16'(`FC_ERASE_SUSP_CYC - 1);
            end else if (op_prog_zero) begin
               op_next = OP_IDLE;
            end
         end
         OP_SUSPENDING: begin
            if (!hve_n) begin
               op_next = OP_ABORTING;
               op_dly_load = 1'b1;
               op_dly_val = 16'(`FC_OP_ABORT_CYC - 1);
            end else if (!psp_n && !esp_n) begin
               op_next = OP_RUN;
            end else if (op_dly_zero) begin
               op_next = OP_SUSPENDED;
            end
         end
         OP_SUSPENDED: begin
            if (!hve_n) begin
               // Nothing is moving, so an abort here completes at once.
               op_next = OP_IDLE;
            end else if (!psp_n && !esp_n) begin
               op_next = OP_RUN;
            end
         end
         OP_ABORTING: begin
            if (op_dly_zero) begin
               op_next = OP_IDLE;
            end
         end
         default: begin
            op_next = OP_IDLE;
         end
      endcase
   end

   assign op_done_next = (op_next == OP_IDLE) || (op_next == OP_SUSPENDED);

   // Integrity check owns the read timer while it is reading.
   assign ck_owns = (ck_state_reg == CK_READ);
   assign ck_rd_done = owner_ck_reg && rd_bus.done;
   assign ck_last = (blk_q == 2'h0) ? `FC_LAST_16K :
                    (blk_q == 2'h1) ? `FC_LAST_32K :
                    (blk_q == 2'h2) ? `FC_LAST_64K : `FC_LAST_256K;
   wire ck_at_end = ck_rd_done && (ck_addr_reg == ck_last);
   assign ck_valid = ck_en_n && !ck_sus_n && !(ck_rd_done && (ck_at_end || ck_bp_n));

   // Integrity check and margin read sequencer.
   always_comb begin
      ck_next = ck_state_reg;
      ck_dly_load = 1'b0;
      ck_abort_next = ck_abort_reg;
      case (ck_state_reg)
         CK_IDLE: begin
            if (ck_en_rise && ready_reg) begin
               ck_next = CK_READ;
            end
         end
         CK_READ: begin
            if (!ck_en_n) begin
               ck_next = CK_STOP;
               ck_dly_load = 1'b1;
               ck_abort_next = 1'b1;
            end else if (ck_sus_n) begin
               ck_next = CK_STOP;
               ck_dly_load = 1'b1;
               ck_abort_next = 1'b0;
            end else if (ck_at_end) begin
               ck_next = CK_IDLE;
            end else if (ck_rd_done && ck_bp_n) begin
               ck_next = CK_HALT;
            end
         end
         CK_STOP: begin
            if (ck_dly_zero) begin
               ck_next = ck_abort_reg ? CK_IDLE : CK_HALT;
            end
         end
         CK_HALT: begin
            if (!ck_en_n) begin
               ck_next = CK_IDLE;
            end else if (!ck_sus_n && !ck_bp_n) begin
               ck_next = CK_READ;
            end
         end
         default: begin
            ck_next = CK_IDLE;
         end
      endcase
   end

   assign ck_done_next = (ck_next == CK_IDLE) || (ck_next == CK_HALT);

   assign wake_act_next = lpm_fall ? 1'b1 : (wake_zero ? 1'b0 : wake_act_reg);
   assign ready_next = !lpm_n && !wake_act_next;

   // Sticky interrupt flags; a new event wins over a same-cycle clear.
   assign irq_event[`FC_IRQ_OPDONE] = op_done_next && !op_done_reg;
   assign irq_event[`FC_IRQ_CKDONE] = ck_done_next && !ck_done_reg;
   assign irq_event[`FC_IRQ_READY] = ready_next && !ready_reg;
   assign irq_stat_next = (irq_stat_reg & ~irq_w1c) | irq_event;
   assign o_irq = |(irq_stat_reg & irq_mask_reg);

   // Register file and interrupt state.
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         module_config_reg <= `FC_CFG_RST;
         user_test_reg <= `FC_TEST_RST;
         platform_flash_config_reg <= `FC_PCFG_RST;
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
         prdata_reg <= 32'h0;
      end else begin
         module_config_reg <= cfg_next;
         user_test_reg <= test_next;
         platform_flash_config_reg <= pcfg_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         if (i_psel && !i_penable && !i_pwrite) begin
            prdata_reg <= rd_mux;
         end
      end
   end

   // Sequencer state and flags.
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         op_state_reg <= OP_IDLE;
         ck_state_reg <= CK_IDLE;
         op_done_reg <= 1'b1;
         ck_done_reg <= 1'b1;
         ready_reg <= 1'b1;
         wake_act_reg <= 1'b0;
         ck_abort_reg <= 1'b0;
      end else begin
         op_state_reg <= op_next;
         ck_state_reg <= ck_next;
         op_done_reg <= op_done_next;
         ck_done_reg <= ck_done_next;
         ready_reg <= ready_next;
         wake_act_reg <= wake_act_next;
         ck_abort_reg <= ck_abort_next;
      end
   end

   // Check address walks the block one read at a time.
   always_ff @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         ck_addr_reg <= 13'h0000;
         ck_first_reg <= 1'b1;
         owner_ck_reg <= 1'b0;
      end else begin
         if (ck_state_reg == CK_IDLE && ck_next == CK_READ) begin
            ck_addr_reg <= 13'h0000;
            ck_first_reg <= 1'b1;
         end else begin
            if (ck_owns && ck_rd_done && ck_en_n && !ck_sus_n) begin
               ck_addr_reg <= ck_addr_reg + 13'h0001;
            end
            if (ck_owns && rd_accept) begin
               ck_first_reg <= 1'b0;
            end
         end
         if (rd_accept) begin
            owner_ck_reg <= ck_owns;
         end
      end
   end

   // Shared read path; host reads stall while the check reads or the array wakes.
   assign rd_bus.valid = ck_owns ? ck_valid : (i_rd_valid && ready_reg);
   assign rd_bus.hit = ck_owns ? 1'b0 : i_rd_hit;
   assign rd_bus.seq = ck_owns ? !ck_first_reg : i_rd_seq;
   assign rd_accept = rd_bus.valid && rd_bus.ready;
   assign o_rd_ready = !ck_owns && ready_reg && rd_bus.ready;
   assign o_rd_done = rd_bus.done && !owner_ck_reg;
   assign o_op_done = op_done_reg;
   assign o_chk_done = ck_done_reg;
   assign o_array_ready = ready_reg;

   fc_rd_timer u_rd_timer (
      .i_clk(i_mclk),
      .i_rst_n(rst_n),
      .i_wait(wait_q),
      .i_pipe(pipe_q),
      .rd(rd_bus)
   );

   // Operation progress only advances while running, so suspend keeps its place.
   fc_timer #(.W(16)) u_op_prog (
      .i_clk(i_mclk),
      .i_rst_n(rst_n),
      .i_load(op_prog_load),
      .i_value(16'(P_OP_CYCLES - 1)),
      .i_run(op_state_reg == OP_RUN),
      .o_zero(op_prog_zero)
   );

   fc_timer #(.W(16)) u_op_dly (
      .i_clk(i_mclk),
      .i_rst_n(rst_n),
      .i_load(op_dly_load),
      .i_value(op_dly_val),
      .i_run(1'b1),
      .o_zero(op_dly_zero)
   );

   // Margin reads stop far slower than array integrity reads.
   fc_timer #(.W(16)) u_ck_dly (
      .i_clk(i_mclk),
      .i_rst_n(rst_n),
      .i_load(ck_dly_load),
      .i_value(margin_n ? 16'(`FC_MARGIN_STOP_CYC - 1) : 16'(`FC_CHECK_STOP_CYC - 1)),
      .i_run(1'b1),
      .o_zero(ck_dly_zero)
   );

   fc_timer #(.W(16)) u_wake (
      .i_clk(i_mclk),
      .i_rst_n(rst_n),
      .i_load(lpm_fall),
      .i_value(16'(P_WAKE_CYCLES - 1)),
      .i_run(wake_act_reg),
      .o_zero(wake_zero)
   );
endmodule

// ---- dv/fc_flash_ctrl_checker.sv ----
// fc_flash_ctrl_checker.sv: port timing assertions of the flash controller.
// Assumes it is bound to fc_flash_ctrl and that software drives APB as the bench does.
`timescale 1ns/1ps
module fc_flash_ctrl_checker #(
   parameter int unsigned P_OP_CYCLES = 1000,
   parameter int unsigned P_WAKE_CYCLES = 4507
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic i_rd_valid,
   input wire logic i_rd_hit,
   input wire logic i_rd_seq,
   input wire logic o_rd_ready,
   input wire logic o_rd_done,
   input wire logic o_op_done,
   input wire logic o_chk_done,
   input wire logic o_array_ready,
   input wire logic o_irq
);
   localparam int WK_HI = P_WAKE_CYCLES + 2;
   logic [7:0] sh_reg [6];
   logic pend_reg;
   logic [3:0] cnt_reg;
   logic [3:0] exp_reg;
   // Decode of writes and of the read latency software configured.
   wire wr = i_psel && i_penable && i_pwrite;
   wire mapped = i_paddr[1:0] == 2'h0 && i_paddr <= 8'h14;
   wire [3:0] miss = 4'h3 + {1'b0, sh_reg[3][2:0]} - (i_rd_seq ? {2'h0, sh_reg[3][5:4]} : 4'h0);
   wire [3:0] lat = (i_rd_hit || miss == 4'h0) ? 4'h1 : miss;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   // Shadows of written registers; they ignore hardware side effects on purpose.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int k = 0; k < 6; k++) begin
            sh_reg[k] <= (k == 3) ? 8'h12 : 8'h00;
         end
      end else if (wr && mapped) begin
         sh_reg[i_paddr[4:2]] <= i_pwdata[7:0];
      end
   end
   // Cycles since a read was taken, with the latency it should have.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pend_reg <= 1'b0;
         cnt_reg <= 4'h0;
         exp_reg <= 4'h0;
      end else if (i_rd_valid && o_rd_ready) begin
         pend_reg <= 1'b1;
         cnt_reg <= 4'h1;
         exp_reg <= lat;
      end else if (pend_reg) begin
         pend_reg <= !o_rd_done;
         cnt_reg <= cnt_reg + 4'h1;
      end
   end
   op_start_a: assert property (wr && i_paddr == 8'h00 && i_pwdata[0] && !sh_reg[0][0]
      && o_op_done && o_array_ready |-> ##[1:2] !o_op_done) else $error("op start slow");
   ck_start_a: assert property (wr && i_paddr == 8'h08 && i_pwdata[0] && !sh_reg[2][0]
      && o_chk_done && o_array_ready |-> ##[1:2] !o_chk_done) else $error("check start slow");
   ck_stop_a: assert property (wr && i_paddr == 8'h08 && sh_reg[2][0] && !sh_reg[2][3]
      && !o_chk_done && (!i_pwdata[0] || (i_pwdata[1] && !sh_reg[2][1]))
      |-> ##[1:24] o_chk_done) else $error("check stop slow");
   wake_a: assert property (wr && i_paddr == 8'h00 && !i_pwdata[4] && sh_reg[0][4]
      |-> ##[1:WK_HI] o_array_ready) else $error("wake recovery slow");
   rd_late_a: assert property (pend_reg |-> cnt_reg <= exp_reg)
      else $error("read done late");
   rd_early_a: assert property (pend_reg && o_rd_done |-> cnt_reg + 4'h1 >= exp_reg)
      else $error("read done early");
   irq_mask_a: assert property (wr && i_paddr == 8'h14 && i_pwdata[2:0] == 3'h0 |=> !o_irq)
      else $error("masked irq seen");
   apb_err_a: assert property (i_psel && i_penable |-> o_pslverr == !mapped)
      else $error("bad error response");
endmodule
bind fc_flash_ctrl fc_flash_ctrl_checker #(.P_OP_CYCLES(P_OP_CYCLES),
   .P_WAKE_CYCLES(P_WAKE_CYCLES)) i_fc_flash_ctrl_checker (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
   .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .i_rd_valid(i_rd_valid), .i_rd_hit(i_rd_hit), .i_rd_seq(i_rd_seq), .o_rd_ready(o_rd_ready),
   .o_rd_done(o_rd_done), .o_op_done(o_op_done), .o_chk_done(o_chk_done),
   .o_array_ready(o_array_ready), .o_irq(o_irq));

// ---- dv/tb_top.sv ----
// tb_top.sv: directed bench of the flash controller through APB and the read port.
// Assumes the checker binds itself; the wake count is cut down by a parameter.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
   $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module tb_top;
   logic i_mclk = 1'b0, i_rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, e;
   logic rv = 1'b0, rh = 1'b0, rs = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, d;
   wire [31:0] prdata;
   wire pready, perr, rrdy, rdone, opd, ckd, ardy, irq;
   int failures = 0, comparisons = 0, n;
   int rw[3] = '{'h00, 'h13, 'h12}, rl[3] = '{3, 6, 5};
   int cs[4] = '{1, 1, 9, 9}, cp[4] = '{0, 3, 8, 11}, chi[4] = '{24, 24, 2047, 2047};
   always #5 i_mclk = ~i_mclk;
   // Program length is raised so a suspend or abort always lands mid-operation.
   fc_flash_ctrl #(.P_OP_CYCLES(2500), .P_WAKE_CYCLES(20)) i_fc_flash_ctrl (.i_mclk(i_mclk),
      .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr),
      .i_rd_valid(rv), .i_rd_hit(rh), .i_rd_seq(rs), .o_rd_ready(rrdy), .o_rd_done(rdone),
      .o_op_done(opd), .o_chk_done(ckd), .o_array_ready(ardy), .o_irq(irq));
   task wrap_up;
      $display("counts: %0d failures, %0d comparisons", failures, comparisons);
      if (failures == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // One clock of a bounded wait; running out ends the run as a failure.
   task tick(input int lim);
      @(posedge i_mclk);
      n++;
      if (n > lim) begin
         failures++;
         wrap_up();
      end
   endtask
   // One APB transfer; read data and error are taken at the pready edge.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge i_mclk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge i_mclk);
      pen <= 1'b1;
      n = 0;
      do tick(20); while (pready !== 1'b1);
      d = prdata;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // Waits for a done or ready flag and checks the edges counted since the last write.
   task meas(input int sel, input int lo, input int hi);
      n = 0;
      do tick(3000); while (((sel == 0) ? opd : (sel == 1) ? ckd : ardy) !== 1'b1);
      `CHK(n inside {[lo:hi]}, 1'b1)
   endtask
   task rd(input logic h, input logic s, input int lat);
      @(posedge i_mclk);
      rv <= 1'b1;
      rh <= h;
      rs <= s;
      n = 0;
      do tick(20); while (rrdy !== 1'b1);
      rv <= 1'b0;
      n = 0;
      do tick(20); while (rdone !== 1'b1);
      `CHK(n inside {[lat - 1:lat]}, 1'b1)
   endtask
   task go(input int w);
      apb(1'b1, 8'h08, w);
      repeat (2) @(posedge i_mclk);
      `CHK(ckd, 1'b0)
   endtask
   initial begin
      repeat (12) @(posedge i_mclk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_mclk);
      apb(1'b0, 8'h0c, 0);
      `CHK(d, 32'h12)
      apb(1'b0, 8'h04, 0);
      `CHK(d[2:0], 3'h7)
      apb(1'b0, 8'h20, 0);
      `CHK({e, d}, 33'h100000000)
      foreach (rw[i]) begin
         apb(1'b1, 8'h0c, rw[i]);
         rd(1'b0, 1'b0, rl[i]);
         rd(1'b1, 1'b0, 1);
      end
      rd(1'b0, 1'b1, 4);
      apb(1'b1, 8'h14, 1);
      apb(1'b1, 8'h00, 1);
      meas(0, 2499, 2502);
      @(posedge i_mclk);
      `CHK(irq, 1'b1)
      apb(1'b1, 8'h10, 1);
      @(posedge i_mclk);
      `CHK(irq, 1'b0)
      apb(1'b1, 8'h00, 0);
      apb(1'b1, 8'h00, 1);
      apb(1'b1, 8'h00, 3);
      meas(0, 943, 1155);
      apb(1'b1, 8'h00, 1);
      repeat (2) @(posedge i_mclk);
      `CHK(opd, 1'b0)
      apb(1'b1, 8'h00, 0);
      meas(0, 1, 2085);
      apb(1'b1, 8'h00, 9);
      apb(1'b1, 8'h00, 13);
      meas(0, 1603, 2085);
      apb(1'b1, 8'h00, 16);
      apb(1'b1, 8'h00, 0);
      `CHK(ardy, 1'b0)
      meas(2, 1, 21);
      // Each stop kind: start, stop, then restart or resume, then abort.
      foreach (cs[i]) begin
         go(cs[i]);
         apb(1'b1, 8'h08, cp[i]);
         meas(1, (i < 2) ? 1 : 1039, chi[i]);
         go(cs[i]);
         apb(1'b1, 8'h08, 0);
         meas(1, 1, chi[i]);
      end
      go(1);
      meas(1, 2047, 2052);
      apb(1'b1, 8'h14, 0);
      wrap_up();
   end
endmodule
